// *** rtl/bils_pkg.sv ***
/*
 Package for the blit and image load setup block: register indices, field
 positions, format codes and the packed types shared by the design files.
 Assumes an APB master with 32-bit data and byte strobes.
*/
`default_nettype none
package bils_pkg;
   // Byte address layout: [15:8] page, [7:2] register index
   localparam logic [7:0] REG_PAGE = 8'h1c;
   localparam logic [7:0] START_PAGE = 8'h1d;
   localparam logic [15:0] WIN_TOP = 16'h1bff;
   localparam int unsigned PAGE_MSB = 15;
   localparam int unsigned PAGE_LSB = 8;
   localparam int unsigned IDX_MSB = 7;
   localparam int unsigned IDX_LSB = 2;
   localparam logic [5:0] IDX_END = 6'h00;
   localparam logic [5:0] IDX_START = 6'h01;
   localparam logic [5:0] IDX_STEP = 6'h02;
   localparam logic [5:0] IDX_XBND = 6'h03;
   localparam logic [5:0] IDX_YCNT = 6'h04;
   localparam logic [5:0] IDX_YST = 6'h05;
   localparam logic [5:0] IDX_LCNT = 6'h06;
   localparam logic [5:0] IDX_CTL = 6'h07;
   localparam logic [5:0] IDX_MACC = 6'h08;
   localparam logic [5:0] IDX_BACK_COLOUR_REG = 6'h09;
   localparam logic [5:0] IDX_FORE_COLOUR_REG = 6'h0a;
   localparam logic [5:0] IDX_PLANE = 6'h0b;
   localparam logic [5:0] IDX_OPERATION_MODE_REG = 6'h0c;
   localparam logic [5:0] IDX_STAT = 6'h0d;
   localparam int unsigned END_W = 24;
   localparam int unsigned START_W = 18;
   localparam int unsigned LINES_W = 16;
   localparam int unsigned CNT_W = 32;
   // Combined y/count word: count low half, y start high half
   localparam int unsigned YC_Y_LSB = 16;
   // draw_control_word fields
   localparam int unsigned CTL_OP_LSB = 0;
   localparam int unsigned CTL_LINEAR_BIT = 7;
   localparam int unsigned CTL_FMT_LSB = 25;
   localparam logic [3:0] OP_HOST_IMAGE_LOAD = 4'h9;
   // blit_source_format codes
   localparam logic [3:0] FMT_NATIVE = 4'h0;
   localparam logic [3:0] FMT_MONO_LSB = 4'h1;
   localparam logic [3:0] FMT_MONO_WORD = 4'h2;
   localparam logic [3:0] FMT_YUV = 4'h3;
   localparam logic [3:0] FMT_RGB24 = 4'h4;
   localparam logic [3:0] FMT_BGR24 = 4'h5;
   localparam logic [3:0] FMT_RGB32 = 4'h6;
   localparam logic [3:0] FMT_BGR32 = 4'h7;
   // memory_access_cfg depth field, bits 1:0
   localparam logic [1:0] DEPTH_8 = 2'h0;
   localparam logic [1:0] DEPTH_16 = 2'h1;
   localparam logic [1:0] DEPTH_32 = 2'h2;
   localparam logic [1:0] DEPTH_24 = 2'h3;
   localparam logic [5:0] PSIZ_1 = 6'h01;
   localparam logic [5:0] PSIZ_8 = 6'h08;
   localparam logic [5:0] PSIZ_16 = 6'h10;
   localparam logic [5:0] PSIZ_24 = 6'h18;
   localparam logic [5:0] PSIZ_32 = 6'h20;
   localparam logic [5:0] DW_ROUND = 6'h1f;
   localparam int unsigned DW_SHIFT = 5;

   typedef struct packed {
      logic [END_W-1:0] end_addr;
      logic [START_W-1:0] start_addr;
      logic [END_W-1:0] step;
      logic [31:0] xbnd;
      logic [LINES_W-1:0] ystart;
      logic [LINES_W-1:0] lines;
      logic [31:0] ctl;
      logic [31:0] macc;
      logic [31:0] back_colour_reg;
      logic [31:0] fore_colour_reg;
      logic [31:0] plane;
      logic [31:0] operation_mode_reg;
   } bils_regs_t;

   typedef struct packed {
      logic valid;
      logic [31:0] data;
   } bils_img_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_CALC = 3'b010,
      ST_LOAD = 3'b100
   } bils_state_t;
endpackage
`default_nettype wire

// *** rtl/bils_dword_calc.sv ***
/*
 Dword total for one image load: source pixel size from the source format
 and depth, then the padded dword count. Result is registered, so it is
 valid one edge after its inputs settle.
*/
`default_nettype none
module bils_dword_calc (
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic [3:0] i_fmt,
   input wire logic [1:0] i_depth,
   input wire logic [bils_pkg::END_W-1:0] i_end_addr,
   input wire logic [bils_pkg::LINES_W-1:0] i_lines,
   input wire logic i_linear,
   output logic [5:0] o_psiz,
   output logic [bils_pkg::CNT_W-1:0] o_total
);
   typedef struct packed {
      logic [5:0] psiz;
      logic [bils_pkg::CNT_W-1:0] total;
   } bils_calc_t;
   bils_calc_t r;
   bils_calc_t next_r;
   logic [5:0] psiz;
   logic [30:0] bits;
   logic [25:0] dw;
   logic [41:0] prod;

   always_comb begin
      unique case (i_fmt)
         bils_pkg::FMT_NATIVE: begin
            unique case (i_depth)
               bils_pkg::DEPTH_8: psiz = bils_pkg::PSIZ_8;
               bils_pkg::DEPTH_16: psiz = bils_pkg::PSIZ_16;
               bils_pkg::DEPTH_24: psiz = bils_pkg::PSIZ_24;
               bils_pkg::DEPTH_32: psiz = bils_pkg::PSIZ_32;
            endcase
         end
         bils_pkg::FMT_MONO_LSB, bils_pkg::FMT_MONO_WORD: psiz = bils_pkg::PSIZ_1;
         bils_pkg::FMT_YUV: psiz = bils_pkg::PSIZ_16;
         bils_pkg::FMT_RGB24, bils_pkg::FMT_BGR24: psiz = bils_pkg::PSIZ_24;
         bils_pkg::FMT_RGB32, bils_pkg::FMT_BGR32: psiz = bils_pkg::PSIZ_32;
         default: psiz = bils_pkg::PSIZ_32;
      endcase
      // Pixels are end address plus one; linear pads once, xy pads per line
      bits = 31'(psiz) * (31'(i_end_addr) + 31'd1) + 31'(bils_pkg::DW_ROUND);
      dw = 26'(bits >> bils_pkg::DW_SHIFT);
      prod = i_linear ? 42'(dw) : 42'(dw) * 42'(i_lines);
      next_r.psiz = psiz;
      next_r.total = prod[bils_pkg::CNT_W-1:0];
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign o_psiz = r.psiz;
   assign o_total = r.total;

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);

   property p_mono_psiz;
      (i_fmt == bils_pkg::FMT_MONO_LSB || i_fmt == bils_pkg::FMT_MONO_WORD)
         |=> (o_psiz == bils_pkg::PSIZ_1);
   endproperty
   a_mono_psiz: assert property (p_mono_psiz) else $error("mono size not 1");

   property p_linear_total;
      (i_linear && i_fmt == bils_pkg::FMT_RGB32 && i_end_addr == 24'h000003)
         |=> (o_total == 32'h00000004);
   endproperty
   a_linear_total: assert property (p_linear_total) else $error("linear total wrong");
endmodule // bils_dword_calc
`default_nettype wire

// *** rtl/bils_core.sv ***
/*
 Register front end and image-load sequencer of the drawing engine's blit
 setup. APB slave (with byte strobes) holding source address, destination,
 control and colour registers; a write in the start page launches the
 operation; an image load then eats bus writes as image dwords.
 Assumes the drawing datapath always accepts o_img.
*/
// How it works
// - An operation starts only on a register write in the start page, done last
// - End, start and step registers hold the source address set-up; end and step keep 24 bits
// - Source start register keeps 18 bits only
// - Pattern start locates and pins pattern; step register set to 32
// - Image load takes successive bus writes as data, addresses ignored
// - Load ends only after every expected dword; later writes are registers
// - Dword total: linear pads at end, xy pads every line
// - Source pixel size follows source format and depth
`default_nettype none
module bils_core (
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [15:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [3:0] i_pstrb,
   output logic o_pready,
   output logic [31:0] o_prdata,
   output logic o_pslverr,
   output bils_pkg::bils_img_t o_img,
   output logic o_op_start,
   output logic o_busy,
   output bils_pkg::bils_regs_t o_regs
);
   typedef struct packed {
      bils_pkg::bils_regs_t regs;
      bils_pkg::bils_state_t st;
      logic phase;
      logic [bils_pkg::CNT_W-1:0] remain;
      logic [31:0] prdata;
      logic pslverr;
      bils_pkg::bils_img_t img;
      logic op_start;
   } bils_core_st_t;

   bils_core_st_t r;
   bils_core_st_t next_r;
   logic [5:0] psiz;
   logic [bils_pkg::CNT_W-1:0] total;
   logic setup;
   logic wr;
   logic [5:0] idx;
   logic [7:0] page;
   logic reg_hit;
   logic start_hit;
   logic [31:0] ctl_new;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = wd[b*8 +: 8];
         end
      end
      return res;
   endfunction

   bils_dword_calc u_calc (
      .i_clk_sys(i_clk_sys),
      .i_sys_rst(i_sys_rst),
      .i_fmt(r.regs.ctl[bils_pkg::CTL_FMT_LSB +: 4]),
      .i_depth(r.regs.macc[1:0]),
      .i_end_addr(r.regs.end_addr),
      .i_lines(r.regs.lines),
      .i_linear(r.regs.ctl[bils_pkg::CTL_LINEAR_BIT]),
      .o_psiz(psiz),
      .o_total(total)
   );

   assign o_pready = (r.st != bils_pkg::ST_CALC);
   assign setup = i_psel && !i_penable;
   assign wr = i_psel && i_penable && o_pready && i_pwrite;
   assign idx = i_paddr[bils_pkg::IDX_MSB:bils_pkg::IDX_LSB];
   assign page = i_paddr[bils_pkg::PAGE_MSB:bils_pkg::PAGE_LSB];
   assign reg_hit = (page == bils_pkg::REG_PAGE) || (page == bils_pkg::START_PAGE);
   assign start_hit = (page == bils_pkg::START_PAGE);
   // Control word as it stands after this write, for the opcode test
   assign ctl_new = merge(r.regs.ctl, i_pwdata, (idx == bils_pkg::IDX_CTL) ? i_pstrb : 4'h0);

   always_comb begin
      next_r = r;
      next_r.img.valid = 1'b0;
      next_r.op_start = 1'b0;
      // Read data and error captured in the setup cycle
      if (setup) begin
         next_r.prdata = '0;
         next_r.pslverr = 1'b0;
         if (reg_hit) begin
            unique case (idx)
               bils_pkg::IDX_END: next_r.prdata = 32'(r.regs.end_addr);
               bils_pkg::IDX_START: next_r.prdata = 32'(r.regs.start_addr);
               bils_pkg::IDX_STEP: next_r.prdata = 32'(r.regs.step);
               bils_pkg::IDX_XBND: next_r.prdata = r.regs.xbnd;
               bils_pkg::IDX_YCNT: next_r.prdata = {r.regs.ystart, r.regs.lines};
               bils_pkg::IDX_YST: next_r.prdata = 32'(r.regs.ystart);
               bils_pkg::IDX_LCNT: next_r.prdata = 32'(r.regs.lines);
               bils_pkg::IDX_CTL: next_r.prdata = r.regs.ctl;
               bils_pkg::IDX_MACC: next_r.prdata = r.regs.macc;
               bils_pkg::IDX_BACK_COLOUR_REG: next_r.prdata = r.regs.back_colour_reg;
               bils_pkg::IDX_FORE_COLOUR_REG: next_r.prdata = r.regs.fore_colour_reg;
               bils_pkg::IDX_PLANE: next_r.prdata = r.regs.plane;
               bils_pkg::IDX_OPERATION_MODE_REG: next_r.prdata = r.regs.operation_mode_reg;
               bils_pkg::IDX_STAT: next_r.prdata = r.remain;
               default: next_r.pslverr = 1'b1;
            endcase
         end else if (i_paddr > bils_pkg::WIN_TOP) begin
            next_r.pslverr = 1'b1;
         end
      end
      unique case (r.st)
         bils_pkg::ST_LOAD: begin
            // Every bus write is the next image dword, whatever its address
            if (wr) begin
               next_r.img.valid = 1'b1;
               next_r.img.data = i_pwdata;
               next_r.remain = r.remain - 1'b1;
               if (r.remain == 32'h00000001) begin
                  next_r.st = bils_pkg::ST_IDLE;
               end
            end
         end
         bils_pkg::ST_CALC: begin
            next_r.phase = 1'b1;
            if (r.phase) begin
               next_r.phase = 1'b0;
               next_r.remain = total;
               // A load with nothing to move ends at once
               next_r.st = (total == '0) ? bils_pkg::ST_IDLE : bils_pkg::ST_LOAD;
            end
         end
         bils_pkg::ST_IDLE: begin
            // Surplus dwords after a load land here as register writes
            if (wr && reg_hit) begin
               unique case (idx)
                  bils_pkg::IDX_END: begin
                     next_r.regs.end_addr = bils_pkg::END_W'(merge(32'(r.regs.end_addr),
                        i_pwdata, i_pstrb));
                  end
                  bils_pkg::IDX_START: begin
                     next_r.regs.start_addr = bils_pkg::START_W'(merge(32'(r.regs.start_addr),
                        i_pwdata, i_pstrb));
                  end
                  bils_pkg::IDX_STEP: begin
                     next_r.regs.step = bils_pkg::END_W'(merge(32'(r.regs.step),
                        i_pwdata, i_pstrb));
                  end
                  bils_pkg::IDX_XBND: next_r.regs.xbnd = merge(r.regs.xbnd, i_pwdata, i_pstrb);
                  bils_pkg::IDX_YCNT: begin
                     next_r.regs.lines = i_pwdata[bils_pkg::LINES_W-1:0];
                     next_r.regs.ystart = i_pwdata[bils_pkg::YC_Y_LSB +: bils_pkg::LINES_W];
                  end
                  bils_pkg::IDX_YST: next_r.regs.ystart = i_pwdata[bils_pkg::LINES_W-1:0];
                  bils_pkg::IDX_LCNT: next_r.regs.lines = i_pwdata[bils_pkg::LINES_W-1:0];
                  bils_pkg::IDX_CTL: next_r.regs.ctl = merge(r.regs.ctl, i_pwdata, i_pstrb);
                  bils_pkg::IDX_MACC: next_r.regs.macc = merge(r.regs.macc, i_pwdata, i_pstrb);
                  bils_pkg::IDX_BACK_COLOUR_REG: next_r.regs.back_colour_reg = merge(r.regs.back_colour_reg, i_pwdata, i_pstrb);
                  bils_pkg::IDX_FORE_COLOUR_REG: next_r.regs.fore_colour_reg = merge(r.regs.fore_colour_reg, i_pwdata, i_pstrb);
                  bils_pkg::IDX_PLANE: begin
                     next_r.regs.plane = merge(r.regs.plane, i_pwdata, i_pstrb);
                  end
                  bils_pkg::IDX_OPERATION_MODE_REG: begin
                     // Byte lanes left unstrobed keep the swap field
                     next_r.regs.operation_mode_reg = merge(r.regs.operation_mode_reg, i_pwdata, i_pstrb);
                  end
                  default: next_r.regs = r.regs;
               endcase
               if (start_hit) begin
                  next_r.op_start = 1'b1;
                  if (ctl_new[bils_pkg::CTL_OP_LSB +: 4] == bils_pkg::OP_HOST_IMAGE_LOAD) begin
                     next_r.st = bils_pkg::ST_CALC;
                  end
               end
            end
         end
      endcase
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         r <= '0;
         r.st <= bils_pkg::ST_IDLE;
      end else begin
         r <= next_r;
      end
   end

   assign o_prdata = r.prdata;
   assign o_pslverr = r.pslverr;
   assign o_img = r.img;
   assign o_op_start = r.op_start;
   assign o_busy = (r.st != bils_pkg::ST_IDLE);
   assign o_regs = r.regs;

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);

   property p_start_on_page;
      (wr && start_hit && r.st == bils_pkg::ST_IDLE) |=> o_op_start;
   endproperty
   a_start_on_page: assert property (p_start_on_page) else $error("start missed");

   property p_start_cause;
      o_op_start |-> $past(wr && start_hit && r.st == bils_pkg::ST_IDLE);
   endproperty
   a_start_cause: assert property (p_start_cause) else $error("start without trigger");

   property p_end_kept;
      (wr && r.st == bils_pkg::ST_IDLE && reg_hit && idx == bils_pkg::IDX_END
         && i_pstrb == 4'hf) |=> (o_regs.end_addr == $past(i_pwdata[bils_pkg::END_W-1:0]));
   endproperty
   a_end_kept: assert property (p_end_kept) else $error("end address not stored");

   property p_start_width;
      (setup && !i_pwrite && reg_hit && idx == bils_pkg::IDX_START) |=> (o_prdata[31:18] == '0);
   endproperty
   a_start_width: assert property (p_start_width) else $error("start wider than 18");

   property p_step_32;
      (wr && r.st == bils_pkg::ST_IDLE && reg_hit && idx == bils_pkg::IDX_STEP
         && i_pstrb == 4'hf && i_pwdata == 32'h00000020) |=> (o_regs.step == 24'h000020);
   endproperty
   a_step_32: assert property (p_step_32) else $error("step not stored");

   property p_load_data;
      (r.st == bils_pkg::ST_LOAD && wr) |=> (o_img.valid && o_img.data == $past(i_pwdata));
   endproperty
   a_load_data: assert property (p_load_data) else $error("image dword lost");

   property p_load_end;
      $fell(r.st == bils_pkg::ST_LOAD) |-> ($past(r.remain) == 32'h00000001 && o_img.valid);
   endproperty
   a_load_end: assert property (p_load_end) else $error("load ended early");

   property p_idle_no_img;
      (r.st != bils_pkg::ST_LOAD) |=> !o_img.valid;
   endproperty
   a_idle_no_img: assert property (p_idle_no_img) else $error("data outside load");

   property p_total_taken;
      (r.st == bils_pkg::ST_CALC && r.phase && total != '0)
         |=> (r.st == bils_pkg::ST_LOAD && r.remain == $past(total));
   endproperty
   a_total_taken: assert property (p_total_taken) else $error("count not loaded");

   property p_operation_mode_reg_lanes;
      (wr && r.st == bils_pkg::ST_IDLE && reg_hit && idx == bils_pkg::IDX_OPERATION_MODE_REG
         && !i_pstrb[2]) |=> $stable(o_regs.operation_mode_reg[17:16]);
   endproperty
   a_operation_mode_reg_lanes: assert property (p_operation_mode_reg_lanes) else $error("swap bits disturbed");

   c_host_image_load: cover property (r.st == bils_pkg::ST_CALC ##2 r.st == bils_pkg::ST_LOAD);
   c_load_done: cover property ($fell(r.st == bils_pkg::ST_LOAD));
   c_plain_start: cover property (o_op_start && r.st == bils_pkg::ST_IDLE);
endmodule // bils_core
`default_nettype wire

// *** bench/bils_host.sv ***
/*
 APB master model of the host processor that programs the blit setup block.
 Assumes one clock; transfers are started by the testbench through xfer.
*/
`default_nettype none
module bils_host (
   input wire logic i_clk_sys,
   input wire logic i_pready,
   input wire logic [31:0] i_prdata,
   input wire logic i_pslverr,
   output logic o_psel,
   output logic o_penable,
   output logic o_pwrite,
   output logic [15:0] o_paddr,
   output logic [31:0] o_pwdata,
   output logic [3:0] o_pstrb
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_psel = 1'b0;
      o_penable = 1'b0;
      o_pwrite = 1'b0;
      o_paddr = 16'h0000;
      o_pwdata = 32'h00000000;
      o_pstrb = 4'h0;
   end
   // One whole transfer; strobes kept for 16-bit mode writes
   task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] rd, output logic err);
      @(posedge i_clk_sys);
      o_psel <= 1'b1;
      o_penable <= 1'b0;
      o_pwrite <= w;
      o_paddr <= a;
      o_pwdata <= d;
      o_pstrb <= s;
      @(posedge i_clk_sys);
      o_penable <= 1'b1;
      // Ready moves only at rising edges, so this level is the one the edge samples
      do @(negedge i_clk_sys); while (i_pready !== 1'b1);
      @(posedge i_clk_sys);
      // Read data and error stand until the next setup cycle
      rd = i_prdata;
      err = i_pslverr;
      o_psel <= 1'b0;
      o_penable <= 1'b0;
      // Released lines show no stale value
      o_paddr <= ~a;
      o_pwdata <= ~d;
   endtask
endmodule // bils_host
`default_nettype wire

// *** bench/testbench.sv ***
/*
 Self-checking bench for bils_core: register access, start page, image load.
 Assumes the host model bils_host drives the APB side.
*/
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, op_start, busy;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic err;
   bils_pkg::bils_img_t img;
   bils_pkg::bils_regs_t regs;
   int failures = 0;
   int comparisons = 0;
   int cycles = 0;
   int img_cnt = 0;
   int start_cnt = 0;
   logic [31:0] img_last;
   bils_core bils_core_inst (.i_clk_sys(clk), .i_sys_rst(rst), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
      .i_pstrb(pstrb), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
      .o_img(img), .o_op_start(op_start), .o_busy(busy), .o_regs(regs));
   bils_host bils_host_inst (.i_clk_sys(clk), .i_pready(pready), .i_prdata(prdata),
      .i_pslverr(pslverr), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
      .o_paddr(paddr), .o_pwdata(pwdata), .o_pstrb(pstrb));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (img.valid === 1'b1) begin
         img_cnt <= img_cnt + 1;
         img_last <= img.data;
      end
      if (op_start === 1'b1) start_cnt <= start_cnt + 1;
      if (cycles == 20000) begin
         failures = failures + 1;
         wrap_up();
      end
   end
   task automatic wrap_up();
      if (failures == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons = comparisons + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [15:0] ra(input logic [7:0] pg, input logic [5:0] idx);
      return {pg, idx, 2'b00};
   endfunction
   task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
      bils_host_inst.xfer(1'b1, a, d, s, rd, err);
   endtask
   task automatic rdr(input logic [5:0] idx);
      bils_host_inst.xfer(1'b0, ra(bils_pkg::REG_PAGE, idx), 32'h00000000, 4'h0, rd, err);
   endtask
   task automatic t_regs();
      rdr(bils_pkg::IDX_END);
      check(rd, 32'h00000000);
      wr(ra(bils_pkg::REG_PAGE, bils_pkg::IDX_START), 32'hffffffff);
      rdr(bils_pkg::IDX_START);
      check(rd, 32'h0003ffff);
      wr(ra(bils_pkg::REG_PAGE, bils_pkg::IDX_END), 32'h12345678);
      rdr(bils_pkg::IDX_END);
      check(rd, 32'h00345678);
      rdr(6'h0e);
      check({31'h0, err}, 32'h00000001);
      wr(ra(bils_pkg::REG_PAGE, bils_pkg::IDX_OPERATION_MODE_REG), 32'h00030000);
      wr(ra(bils_pkg::REG_PAGE, bils_pkg::IDX_OPERATION_MODE_REG), 32'h0000abcd, 4'h3);
      rdr(bils_pkg::IDX_OPERATION_MODE_REG);
      check(rd, 32'h0003abcd);
      wr(ra(bils_pkg::REG_PAGE, bils_pkg::IDX_YCNT), 32'h00050007);
      wr(ra(bils_pkg::REG_PAGE, bils_pkg::IDX_YST), 32'h00000009);
      wr(ra(bils_pkg::REG_PAGE, bils_pkg::IDX_LCNT), 32'h00000003);
      @(negedge clk);
      check({16'h0, regs.ystart}, 32'h00000009);
      check({16'h0, regs.lines}, 32'h00000003);
   endtask
   task automatic wreg(input logic [5:0] idx, input logic [31:0] d);
      wr(ra(bils_pkg::REG_PAGE, idx), d);
   endtask
   // Launches a non-load operation last; it must start and leave the block idle
   task automatic go(input logic [31:0] ctl);
      int s0;
      s0 = start_cnt;
      wr(ra(bils_pkg::START_PAGE, bils_pkg::IDX_CTL), ctl);
      repeat (2) @(negedge clk);
      check(start_cnt - s0, 1);
      check({31'h0, busy}, 32'h00000000);
      check(regs.ctl, ctl);
   endtask
   // Copy, colour pattern and expansion set-ups as the host must make them
   task automatic t_setups();
      // Depth 16 copy: start and left bound agree modulo 32
      wreg(bils_pkg::IDX_MACC, 32'h00000001);
      wreg(bils_pkg::IDX_END, 32'h0000013f);
      wreg(bils_pkg::IDX_START, 32'h00000120);
      wreg(bils_pkg::IDX_STEP, 32'h00000400);
      wreg(bils_pkg::IDX_XBND, 32'h01400040);
      wreg(bils_pkg::IDX_YCNT, 32'h00100008);
      go(32'h040a600c);
      check(regs.xbnd, 32'h01400040);
      // Depth 32 copy: both sides 5 modulo 32, fit with or without interleave
      wreg(bils_pkg::IDX_MACC, 32'h00000002);
      wreg(bils_pkg::IDX_END, 32'h000001c4);
      wreg(bils_pkg::IDX_START, 32'h000001a5);
      wreg(bils_pkg::IDX_XBND, 32'h00800025);
      go(32'h040a600c);
      check({14'h0, regs.start_addr}, 32'h000001a5);
      // Depth 8 pattern in slot 0 at 100h, offset x 3 and y 2
      wreg(bils_pkg::IDX_MACC, 32'h00000000);
      wreg(bils_pkg::IDX_START, 32'h00000143);
      wreg(bils_pkg::IDX_END, 32'h00000145);
      wreg(bils_pkg::IDX_STEP, 32'h00000020);
      go(32'h000c6008);
      check({8'h0, regs.step}, 32'h00000020);
      check({8'h0, regs.end_addr}, 32'h00000145);
      // Planar expansion at depth 16 with plane and background colour
      wreg(bils_pkg::IDX_MACC, 32'h00000001);
      wreg(bils_pkg::IDX_PLANE, 32'h00000003);
      wreg(bils_pkg::IDX_BACK_COLOUR_REG, 32'h00001234);
      go(32'h000c0008);
      check(regs.plane, 32'h00000003);
      // Depth 24 expansion with uniform colour bytes
      wreg(bils_pkg::IDX_MACC, 32'h00000003);
      wreg(bils_pkg::IDX_FORE_COLOUR_REG, 32'h66666666);
      wreg(bils_pkg::IDX_BACK_COLOUR_REG, 32'h99999999);
      go(32'h000c0008);
      check(regs.fore_colour_reg, 32'h66666666);
      check(regs.back_colour_reg, 32'h99999999);
   endtask
   // Sets up a load, starts it last, feeds exactly the expected dwords
   task automatic t_load(input logic [3:0] fmt, input logic [1:0] dep, input logic lin,
                         input logic [23:0] e, input logic [15:0] n, input int exp);
      int s0, i0;
      s0 = start_cnt;
      wr(ra(bils_pkg::REG_PAGE, bils_pkg::IDX_MACC), {30'h0, dep});
      wr(ra(bils_pkg::REG_PAGE, bils_pkg::IDX_END), {8'h0, e});
      wr(ra(bils_pkg::REG_PAGE, bils_pkg::IDX_START), 32'h00000000);
      wr(ra(bils_pkg::REG_PAGE, bils_pkg::IDX_STEP), 32'h00000000);
      wr(ra(bils_pkg::REG_PAGE, bils_pkg::IDX_LCNT), {16'h0, n});
      wr(ra(bils_pkg::REG_PAGE, bils_pkg::IDX_CTL), {3'h0, fmt, 17'h0, lin, 7'h09});
      check(start_cnt - s0, 0);
      wr(ra(bils_pkg::START_PAGE, bils_pkg::IDX_CTL), {3'h0, fmt, 17'h0, lin, 7'h09});
      repeat (2) @(negedge clk);
      check(start_cnt - s0, 1);
      rdr(bils_pkg::IDX_STAT);
      check(rd, exp);
      i0 = img_cnt;
      for (int i = 0; i < exp; i++) begin
         @(negedge clk);
         check({31'h0, busy}, 32'h00000001);
         // Register addresses too: all are image data now
         wr((i == 0) ? ra(bils_pkg::REG_PAGE, bils_pkg::IDX_END) : 16'(4 * i),
            32'hc0de0000 + i);
      end
      repeat (2) @(negedge clk);
      check(img_cnt - i0, exp);
      if (exp > 0) check(img_last, 32'hc0de0000 + exp - 1);
      check({31'h0, busy}, 32'h00000000);
      rdr(bils_pkg::IDX_END);
      check(rd, {8'h0, e});
      wr(ra(bils_pkg::REG_PAGE, bils_pkg::IDX_BACK_COLOUR_REG), 32'h5a5a5a5a);
      rdr(bils_pkg::IDX_BACK_COLOUR_REG);
      check(rd, 32'h5a5a5a5a);
   endtask
   task automatic t_formats();
      logic [5:0] ps[8];
      logic [5:0] nat[4];
      ps = '{6'd8, 6'd1, 6'd1, 6'd16, 6'd24, 6'd24, 6'd32, 6'd32};
      nat = '{6'd8, 6'd16, 6'd32, 6'd24};
      // Four pixels, linear: dwords are psiz*4 rounded up
      for (int f = 1; f < 8; f++) begin
         t_load(4'(f), 2'h0, 1'b1, 24'd3, 16'd1, (ps[f] * 4 + 31) / 32);
      end
      for (int d = 0; d < 4; d++) begin
         t_load(4'h0, 2'(d), 1'b1, 24'd3, 16'd1, (nat[d] * 4 + 31) / 32);
      end
   endtask
   task automatic t_padding();
      t_load(4'h1, 2'h0, 1'b1, 24'd39, 16'd3, 2);
      t_load(4'h1, 2'h0, 1'b0, 24'd39, 16'd3, 6);
      t_load(4'h4, 2'h0, 1'b0, 24'd2, 16'd2, 6);
      t_load(4'h0, 2'h0, 1'b0, 24'd0, 16'd0, 0);
   endtask
   initial begin
      rst = 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_setups();
      t_formats();
      t_padding();
      wrap_up();
   end
endmodule // testbench
`default_nettype wire
